// [verilog/override_cfg.svh]
`ifndef OVERRIDE_CFG_SVH
`define OVERRIDE_CFG_SVH
// Overview of operation
// [RULE_01] each block takes a one-bit manual override input and processes it
// [RULE_02] auto mode: override on forces start telegrams, no brightness check
// [RULE_03] auto mode: override on simulates presence, starts transmission delay
// [RULE_04] ceiling: delay expiry sends end telegrams; motion restarts delay
// [RULE_05] presence: brightness above limit during motion ends after off delay
// [RULE_06] auto mode: override off forces end, clears detection, then lockout
// [RULE_07] semi I: override on forces start, starts delay, enables detection
// [RULE_08] semi I: detection disabled after end telegrams are sent
// [RULE_09] semi I: override off ends, clears and disables; needs override on
// [RULE_10] semi II: override on forces start, simulates presence, no delay
// [RULE_11] semi II: partner sends override off; device then sends end
// [RULE_12] light control: pass override value on and start presence
// [RULE_13] external motion checked with twilight or not; auto off at end
// [RULE_14] no twilight evaluation: every motion starts or restarts delay
// [RULE_15] the switch-off override is the value opposite to switch-on

// ************************************************************
// register map (apb byte addresses)
// ************************************************************
`define OVR_ADDR_CTRL 12'h000
`define OVR_ADDR_DELAY 12'h004
`define OVR_ADDR_OFFDLY 12'h008
`define OVR_ADDR_LOCK 12'h00c
`define OVR_ADDR_STATUS 12'h010
`define OVR_ADDR_CMD 12'h014

// ctrl field positions
`define OVR_CTRL_MODE_LSB 0
`define OVR_CTRL_MODE_MSB 1
`define OVR_CTRL_PRESENCE 2
`define OVR_CTRL_LIGHTCTL 3
`define OVR_CTRL_TWI_EXT 4
`define OVR_CTRL_OUT1_EN 5
`define OVR_CTRL_OUT2_EN 6

// reset values
`define OVR_CTRL_RESET 32'h0000_0060
`define OVR_DELAY_RESET 32'h0000_0064
`define OVR_OFFDLY_RESET 32'h0000_0064
`define OVR_LOCK_RESET 32'h0000_0032

// timing: delays count in ticks of this many ns
`define OVR_TICK_NS 1000
`define OVR_CLK_NS 20
`define OVR_TICK_CYCLES (`OVR_TICK_NS / `OVR_CLK_NS)
`endif

// [verilog/override_pkg.sv]
`default_nettype none
package override_pkg;
  typedef enum logic [1:0] {
    mode_full_auto = 2'b00,
    mode_manual_on_variant_one = 2'b01,
    mode_manual_on_variant_two = 2'b10
  } op_mode_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_detect = 2'b01,
    st_lockout = 2'b10,
    st_disabled = 2'b11
  } det_state_t;

  typedef struct packed {
    logic start_tel;
    logic end_tel;
  } tel_t;

  typedef struct packed {
    logic override_valid;
    logic override_value;
    logic motion;
    logic external_motion;
    logic above_twilight;
    logic above_switch_off;
  } sense_t;
endpackage
`default_nettype wire

// [verilog/tick_timer.sv]
`default_nettype none
// loadable countdown on a prescaled tick
module tick_timer (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic stop_i,
  input wire logic [15:0] value_i,
  output logic busy_o,
  output logic expire_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic busy;
    logic expire;
  } tmr_state_t;
  tmr_state_t s_reg;
  tmr_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.expire = 1'b0;
    if (stop_i) begin
      s_next.busy = 1'b0;
    end else if (load_i) begin
      s_next.busy = 1'b1;
      s_next.cnt = (value_i == 16'h0000) ? 16'h0001 : value_i;
    end else if (s_reg.busy && tick_i) begin
      if (s_reg.cnt == 16'h0001) begin
        s_next.busy = 1'b0;
        s_next.expire = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy_o = s_reg.busy;
  assign expire_o = s_reg.expire;
endmodule
`default_nettype wire

// [verilog/tick_prescaler.sv]
`default_nettype none
`include "override_cfg.svh"
// one-cycle tick every OVR_TICK_CYCLES clocks
module tick_prescaler (
  input wire logic clk_i,
  input wire logic reset_i,
  output logic tick_o
);
  localparam logic [15:0] LAST = 16'(`OVR_TICK_CYCLES - 1);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } pre_state_t;
  pre_state_t s_reg;
  pre_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == LAST) begin
      s_next.cnt = 16'h0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_o = s_reg.tick;
endmodule
`default_nettype wire

// [verilog/manual_override_detection_control.sv]
`default_nettype none
`include "override_cfg.svh"
module manual_override_detection_control (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire override_pkg::sense_t sense_i,
  output override_pkg::tel_t out1_o,
  output override_pkg::tel_t out2_o,
  output logic light_ctl_valid_o,
  output logic light_ctl_value_o,
  output logic presence_o
);
  import override_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] delay;
    logic [15:0] offdly;
    logic [15:0] lock;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    det_state_t st;
    logic presence;
    logic delay_run;
    logic cmd_pending;
    tel_t out1;
    tel_t out2;
    logic lc_valid;
    logic lc_value;
  } top_state_t;
  top_state_t s_reg;
  top_state_t s_next;

  logic tick;
  logic delay_load;
  logic delay_stop;
  logic delay_expire;
  logic off_load;
  logic off_stop;
  logic off_busy;
  logic off_expire;
  logic lock_load;
  logic lock_busy;
  logic lock_expire;

  // ************************************************************
  // timers
  // ************************************************************
  // one shared tick keeps the three delays in the same time base
  tick_prescaler u_pre (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_o(tick)
  );

  // transmission delay
  tick_timer u_delay (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick),
    .load_i(delay_load),
    .stop_i(delay_stop),
    .value_i(s_reg.delay),
    .busy_o(),
    .expire_o(delay_expire)
  );

  // switch-off brightness delay
  tick_timer u_off (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick),
    .load_i(off_load),
    .stop_i(off_stop),
    .value_i(s_reg.offdly),
    .busy_o(off_busy),
    .expire_o(off_expire)
  );

  // lockout after switch-off
  // never stopped: a switch-on override may cut a lockout short
  tick_timer u_lock (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick),
    .load_i(lock_load),
    .stop_i(1'b0),
    .value_i(s_reg.lock),
    .busy_o(lock_busy),
    .expire_o(lock_expire)
  );

  // ************************************************************
  // decoded configuration and inputs
  // ************************************************************
  op_mode_t mode;
  logic is_presence;
  logic is_lightctl;
  logic twi_ext;
  logic ovr_on;
  logic ovr_off;
  logic motion_ok;
  logic apb_wr;
  logic apb_rd;

  always_comb begin
    mode = op_mode_t'(s_reg.ctrl[`OVR_CTRL_MODE_MSB:`OVR_CTRL_MODE_LSB]);
    is_presence = s_reg.ctrl[`OVR_CTRL_PRESENCE];
    is_lightctl = s_reg.ctrl[`OVR_CTRL_LIGHTCTL];
    twi_ext = s_reg.ctrl[`OVR_CTRL_TWI_EXT];
    // software can also inject an override over the bus
    ovr_on = (sense_i.override_valid && sense_i.override_value) // see [RULE_01]
      || s_reg.cmd_pending;
    // off is the opposite value of on
    ovr_off = sense_i.override_valid && !sense_i.override_value; // see [RULE_15]
    // internal motion gated by twilight; external only if twi_ext set
    motion_ok = (sense_i.motion && !sense_i.above_twilight) // see [RULE_14]
      || (sense_i.external_motion
          && !(twi_ext && sense_i.above_twilight)); // see [RULE_13]
  end

  // ************************************************************
  // bus access decode
  // ************************************************************
  // ready still high means this access was already taken
  always_comb begin
    apb_wr = psel_i && penable_i && pwrite_i && !s_reg.ready;
    apb_rd = psel_i && penable_i && !pwrite_i && !s_reg.ready;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.out1 = '0;
    s_next.out2 = '0;
    s_next.lc_valid = 1'b0;
    s_next.ready = 1'b0;
    s_next.slverr = 1'b0;
    delay_load = 1'b0;
    delay_stop = 1'b0;
    off_load = 1'b0;
    off_stop = 1'b0;
    lock_load = 1'b0;
    // a bus-injected override lasts one cycle; a new write re-arms it
    s_next.cmd_pending = 1'b0;

    // ************************************************************
    // apb slave
    // ************************************************************
    // answer one cycle into the access phase; the write lands with the
    // edge that raises pready, while the master still holds it
    if (apb_wr || apb_rd) begin
      s_next.ready = 1'b1;
      // unmapped and write-only addresses read as zero
      s_next.rdata = 32'h0000_0000;
      case (paddr_i)
        `OVR_ADDR_CTRL: begin
          if (apb_wr) begin
            s_next.ctrl = {25'h0000000, pwdata_i[6:0]};
          end
          s_next.rdata = s_reg.ctrl;
        end
        `OVR_ADDR_DELAY: begin
          if (apb_wr) begin
            s_next.delay = pwdata_i[15:0];
          end
          s_next.rdata = {16'h0000, s_reg.delay};
        end
        `OVR_ADDR_OFFDLY: begin
          if (apb_wr) begin
            s_next.offdly = pwdata_i[15:0];
          end
          s_next.rdata = {16'h0000, s_reg.offdly};
        end
        `OVR_ADDR_LOCK: begin
          if (apb_wr) begin
            s_next.lock = pwdata_i[15:0];
          end
          s_next.rdata = {16'h0000, s_reg.lock};
        end
        `OVR_ADDR_STATUS: begin
          s_next.rdata = {28'h0000000, s_reg.presence, s_reg.delay_run,
                          s_reg.st};
        end
        `OVR_ADDR_CMD: begin
          // only a one requests; writing zero does nothing
          if (apb_wr && pwdata_i[0]) begin
            s_next.cmd_pending = 1'b1;
          end
        end
        default: begin
          s_next.slverr = 1'b1;
        end
      endcase
    end

    // ************************************************************
    // override handling
    // ************************************************************
    if (is_lightctl) begin
      // light control owns the override value; we only start presence
      if (sense_i.override_valid) begin
        s_next.lc_valid = 1'b1; // see [RULE_12]
        s_next.lc_value = sense_i.override_value;
      end
      if (ovr_on || ovr_off) begin
        s_next.presence = 1'b1; // see [RULE_12]
      end
    end else if (ovr_off) begin
      // off beats any motion in the same cycle
      s_next.out1.end_tel = s_reg.ctrl[`OVR_CTRL_OUT1_EN]; // see [RULE_06]
      s_next.out2.end_tel = s_reg.ctrl[`OVR_CTRL_OUT2_EN]; // see [RULE_11]
      s_next.presence = 1'b0;
      s_next.delay_run = 1'b0;
      delay_stop = 1'b1;
      off_stop = 1'b1;
      if (mode == mode_manual_on_variant_one) begin
        s_next.st = st_disabled; // see [RULE_09]
      end else begin
        s_next.st = st_lockout; // see [RULE_06]
        lock_load = 1'b1;
      end
    end else if (ovr_on) begin
      // forced, no brightness test, no evaluation delay
      s_next.out1.start_tel = s_reg.ctrl[`OVR_CTRL_OUT1_EN]; // see [RULE_02]
      s_next.out2.start_tel = s_reg.ctrl[`OVR_CTRL_OUT2_EN]; // see [RULE_02]
      s_next.presence = 1'b1; // see [RULE_03]
      // lockout and disabled both give way to a switch-on
      s_next.st = st_detect; // see [RULE_07]
      if (mode == mode_manual_on_variant_two) begin
        s_next.delay_run = 1'b0; // see [RULE_10]
        delay_stop = 1'b1;
      end else begin
        s_next.delay_run = 1'b1; // see [RULE_03]
        delay_load = 1'b1;
      end
    end else begin
      // ********************************************************
      // detection sequence
      // ********************************************************
      case (s_reg.st)
        st_idle: begin
          // a real detection takes the same path as a forced one in auto and semi I
          if (motion_ok) begin
            s_next.st = st_detect;
            s_next.presence = 1'b1;
            s_next.delay_run = 1'b1;
            delay_load = 1'b1; // see [RULE_14]
            s_next.out1.start_tel = s_reg.ctrl[`OVR_CTRL_OUT1_EN];
            s_next.out2.start_tel = s_reg.ctrl[`OVR_CTRL_OUT2_EN];
          end
        end
        st_detect: begin
          // retrigger only while the delay runs; a forced start in semi II keeps it off
          if ((sense_i.motion || sense_i.external_motion)
              && s_reg.delay_run) begin
            delay_load = 1'b1; // see [RULE_04]
          end
          // presence detector: brightness above off limit with motion
          if (is_presence && sense_i.above_switch_off && sense_i.motion) begin
            if (!off_busy) begin
              off_load = 1'b1; // see [RULE_05]
            end
          end else begin
            off_stop = 1'b1;
          end
          if ((delay_expire && s_reg.delay_run) || off_expire) begin
            s_next.out1.end_tel = s_reg.ctrl[`OVR_CTRL_OUT1_EN]; // see [RULE_04]
            s_next.out2.end_tel = s_reg.ctrl[`OVR_CTRL_OUT2_EN]; // see [RULE_05]
            s_next.presence = 1'b0;
            s_next.delay_run = 1'b0;
            // a timer left running would end the next detection early
            delay_stop = 1'b1;
            off_stop = 1'b1;
            if (mode == mode_manual_on_variant_one) begin
              s_next.st = st_disabled; // see [RULE_08]
            end else begin
              s_next.st = st_lockout; // see [RULE_13]
              lock_load = 1'b1;
            end
          end
        end
        st_lockout: begin
          // motion ignored until lockout ends
          // an expired or never loaded lockout both release
          if (lock_expire || !lock_busy) begin
            s_next.st = st_idle; // see [RULE_06]
          end
        end
        st_disabled: begin
          // only an override leaves here: switch-on, or switch-off outside semi I (to lockout)
          s_next.st = st_disabled; // see [RULE_09]
        end
        default: begin
          s_next.st = st_idle;
        end
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
      // configuration restarts with both outputs enabled
      s_reg.ctrl <= `OVR_CTRL_RESET;
      s_reg.delay <= 16'(`OVR_DELAY_RESET);
      s_reg.offdly <= 16'(`OVR_OFFDLY_RESET);
      s_reg.lock <= 16'(`OVR_LOCK_RESET);
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata_o = s_reg.rdata;
  assign pready_o = s_reg.ready;
  assign pslverr_o = s_reg.slverr;
  assign out1_o = s_reg.out1;
  assign out2_o = s_reg.out2;
  assign light_ctl_valid_o = s_reg.lc_valid;
  assign light_ctl_value_o = s_reg.lc_value;
  assign presence_o = s_reg.presence;
endmodule
`default_nettype wire

// [verification/telegram_source.sv]
`default_nettype none
// ************************************************************
// bus telegram sources: pushbutton, extension, sensor levels
// ************************************************************
module telegram_source (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic send_i,
  input wire logic on_i,
  input wire logic [3:0] lvl_i,
  output override_pkg::sense_t sense_o
);
  import override_pkg::*;
  // between telegrams the value bit flips, so no stale level looks valid
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sense_o <= '0;
    end else begin
      sense_o <= {send_i, send_i ? on_i : ~sense_o.override_value,
        lvl_i};
    end
  end
endmodule
`default_nettype wire

// [verification/override_asserts.sv]
`default_nettype none
// ************************************************************
// port checker
// ************************************************************
module override_asserts (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire override_pkg::sense_t sense_i,
  input wire override_pkg::tel_t out1_o,
  input wire override_pkg::tel_t out2_o,
  input wire logic light_ctl_valid_o,
  input wire logic light_ctl_value_o,
  input wire logic presence_o
);
  import override_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  rdy_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready late");
  rdy_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  err_with_rdy_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  start_sets_pres_a: assert property (
    out1_o.start_tel |-> presence_o)
    else $error("start telegram without presence");
  end_drops_pres_a: assert property (
    out1_o.end_tel |-> !presence_o)
    else $error("end telegram with presence");
  tel_pulse_a: assert property (
    out1_o.start_tel |=> !out1_o.start_tel)
    else $error("start telegram held");
  on_starts_a: assert property (
    sense_i.override_valid && sense_i.override_value && !presence_o
    |=> presence_o)
    else $error("override on did not start");
  off_ends_a: assert property (
    sense_i.override_valid && !sense_i.override_value && presence_o
    |=> !presence_o || light_ctl_valid_o)
    else $error("override off did not end");
  pres_fall_end_a: assert property (
    $fell(presence_o) |-> out1_o.end_tel || light_ctl_valid_o)
    else $error("presence ended silently");
  light_pass_a: assert property (
    light_ctl_valid_o |-> $past(sense_i.override_valid) &&
    light_ctl_value_o == $past(sense_i.override_value))
    else $error("light control value wrong");
  cover property (out1_o.end_tel);
  cover property (pslverr_o);
  cover property (light_ctl_valid_o);
endmodule
bind manual_override_detection_control override_asserts override_asserts_inst (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .sense_i(sense_i), .out1_o(out1_o), .out2_o(out2_o),
  .light_ctl_valid_o(light_ctl_valid_o),
  .light_ctl_value_o(light_ctl_value_o), .presence_o(presence_o)
);
`default_nettype wire

// [verification/manual_override_detection_control_bench.sv]
`default_nettype none
`include "override_cfg.svh"
module manual_override_detection_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import override_pkg::*;
  localparam int T = `OVR_TICK_CYCLES;
  logic clk_i = 0, reset_i = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd = 32'h0, prd, q;
  logic prdy, perr, e, lv, lval, pres, send = 0, on = 0;
  logic [3:0] lvl = 4'h0;
  sense_t sense;
  tel_t o1, o2;
  int bad_count = 0, comparisons = 0, n;
  always #10 clk_i = ~clk_i;
  telegram_source telegram_source_inst (.clk_i(clk_i), .reset_i(reset_i),
    .send_i(send), .on_i(on), .lvl_i(lvl), .sense_o(sense));
  manual_override_detection_control manual_override_detection_control_inst (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .sense_i(sense), .out1_o(o1),
    .out2_o(o2), .light_ctl_valid_o(lv), .light_ctl_value_o(lval),
    .presence_o(pres));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x,
    input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    k = 0;
    // answer and read data are both taken at the rising edge
    do begin
      @(posedge clk_i);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    if (prdy !== 1'b1) begin
      chk("pready", 32'h1, {31'h0, prdy});
      summarize();
    end
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic ovr(input logic v);
    @(posedge clk_i);
    send <= 1'b1;
    on <= v;
    @(posedge clk_i);
    send <= 1'b0;
  endtask
  task automatic mot(input logic [3:0] v);
    @(posedge clk_i);
    lvl <= v;
    @(posedge clk_i);
    lvl <= 4'h0;
  endtask
  // both outputs must pulse in the same cycle
  task automatic wev(input logic st, input int lim);
    logic [1:0] m;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      m = st ? {o1.start_tel, o2.start_tel} : {o1.end_tel, o2.end_tel};
    end while (m !== 2'b11 && n < lim);
    chk(st ? "start" : "end", 32'h3, {30'h0, m});
    if (m !== 2'b11) begin
      summarize();
    end
  endtask
  task automatic quiet(input int lim);
    int c;
    c = 0;
    repeat (lim) begin
      @(negedge clk_i);
      if ({o1, o2} !== 4'h0) begin
        c++;
      end
    end
    chk("silence", 32'h0, c);
  endtask
  task automatic lwait(input logic v);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (lv !== 1'b1 && n < 5);
    chk("light valid", 32'h1, {31'h0, lv});
    if (lv !== 1'b1) begin
      summarize();
    end
    chk("light value", {31'h0, v}, {31'h0, lval});
    chk("light presence", 32'h1, {31'h0, pres});
  endtask
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    apb(1'b0, `OVR_ADDR_CTRL, 32'h0);
    chk("ctrl reset", `OVR_CTRL_RESET, q);
    apb(1'b0, `OVR_ADDR_LOCK, 32'h0);
    chk("lock reset", `OVR_LOCK_RESET, q);
    apb(1'b0, 12'h018, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, `OVR_ADDR_DELAY, 32'h4);
    apb(1'b1, `OVR_ADDR_OFFDLY, 32'h2);
    apb(1'b1, `OVR_ADDR_LOCK, 32'h2);
    apb(1'b0, `OVR_ADDR_DELAY, 32'h0);
    chk("delay", 32'h4, q);
    ovr(1'b1);
    wev(1'b1, 5);
    chk("presence", 32'h1, {31'h0, pres});
    wev(1'b0, 5 * T);
    chk("delay span", 32'h1, {31'h0, n > 3 * T - 10});
    ovr(1'b1);
    wev(1'b1, 5);
    repeat (7 * T / 2 - 35) @(posedge clk_i);
    mot(4'h8);
    wev(1'b0, 5 * T);
    chk("retrigger", 32'h1, {31'h0, n > 2 * T});
    ovr(1'b1);
    wev(1'b1, 5);
    ovr(1'b0);
    wev(1'b0, 5);
    mot(4'h8);
    quiet(10);
    repeat (3 * T) @(posedge clk_i);
    apb(1'b1, `OVR_ADDR_CTRL, 32'h70);
    mot(4'h6);
    quiet(10);
    apb(1'b1, `OVR_ADDR_CTRL, 32'h60);
    mot(4'h6);
    wev(1'b1, 10);
    wev(1'b0, 5 * T);
    repeat (3 * T) @(posedge clk_i);
    apb(1'b1, `OVR_ADDR_CTRL, 32'h64);
    ovr(1'b1);
    wev(1'b1, 5);
    @(posedge clk_i);
    lvl <= 4'h9;
    wev(1'b0, 3 * T);
    @(posedge clk_i);
    lvl <= 4'h0;
    repeat (3 * T) @(posedge clk_i);
    apb(1'b1, `OVR_ADDR_CTRL, 32'h61);
    ovr(1'b1);
    wev(1'b1, 5);
    wev(1'b0, 5 * T);
    mot(4'h8);
    quiet(10);
    ovr(1'b1);
    wev(1'b1, 5);
    ovr(1'b0);
    wev(1'b0, 5);
    apb(1'b0, `OVR_ADDR_STATUS, 32'h0);
    chk("status disabled", 32'h3, q);
    mot(4'h8);
    quiet(10);
    apb(1'b1, `OVR_ADDR_CTRL, 32'h62);
    ovr(1'b1);
    wev(1'b1, 5);
    apb(1'b0, `OVR_ADDR_STATUS, 32'h0);
    chk("status no delay", 32'h9, q);
    quiet(5 * T);
    ovr(1'b0);
    wev(1'b0, 5);
    repeat (3 * T) @(posedge clk_i);
    apb(1'b1, `OVR_ADDR_CTRL, 32'h68);
    ovr(1'b1);
    lwait(1'b1);
    ovr(1'b0);
    lwait(1'b0);
    repeat (3 * T) @(posedge clk_i);
    apb(1'b1, `OVR_ADDR_CTRL, 32'h60);
    apb(1'b1, `OVR_ADDR_CMD, 32'h1);
    wev(1'b1, 5);
    ovr(1'b0);
    wev(1'b0, 5);
    summarize();
  end
endmodule
`default_nettype wire
